// ==== rtl/pwm_output_steering.sv ====
// Output steering of a PWM waveform onto four pins, with a Wishbone register slave.
// How it works
// - Steering is honoured only while the mode field high bits select PWM and config is single.
// - Output B carries the PWM waveform when its enable is set and its port value otherwise.
// - Output A carries the PWM waveform when its enable is set and its port value otherwise.
// - Mode bit 0 sets the polarity of the waveform on every steered output; mode bit 1 has no effect.
`include "pwm_steer_defs.svh"
module pwm_output_steering #(
  parameter int NumOut = `NUM_OUTPUTS
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pwmRaw,
  input wire logic periodStart,
  input wire logic [NumOut-1:0] portData,
  output logic [NumOut-1:0] pwmPin
);
  typedef struct packed {
    pwm_steer_pkg::steer_ctrl_s ctrl;
    pwm_steer_pkg::capcomp_s capcomp;
    logic [3:0] activeEnable;
    pwm_steer_pkg::update_e upd;
    logic [31:0] rdata;
    logic ack;
  } state_s;

  state_s st;
  state_s next_st;
  logic steerMode;
  logic pwmPolar;
  logic [NumOut-1:0] steerOn;
  logic busReq;
  logic ctrlWrite;

  assign busReq = wb_cyc_i && wb_stb_i && !st.ack;
  // Only a write on lane 0 to the steering register can move the selection.
  assign ctrlWrite = busReq && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ADDR_STEER_CTRL);
  // The selection is usable only in single-output PWM mode.
  assign steerMode = (st.capcomp.capcompModeHigh == `CAPCOMP_PWM_MODE) &&
    (st.capcomp.pwmOutputConfig == `CAPCOMP_SINGLE_OUT);
  // Mode bit 0 inverts the waveform on every steered pin; mode bit 1 is left
  // without effect, so all steered pins share one polarity.
  assign pwmPolar = pwmRaw ^ st.capcomp.capcompModeLow[0];

  always_comb
  begin
    next_st = st;
    next_st.ack = busReq;
    next_st.rdata = 32'h0;
    if (busReq && wb_we_i && wb_sel_i[0])
    begin
      case (wb_adr_i)
        `ADDR_STEER_CTRL:
        begin
          next_st.ctrl.steerUpdateSync = wb_dat_i[`BIT_STEER_SYNC];
          next_st.ctrl.steerEnable = wb_dat_i[3:0];
        end
        `ADDR_CAPCOMP_CTRL:
          next_st.capcomp = wb_dat_i[5:0];
        default:
          next_st.ctrl = st.ctrl;
      endcase
    end
    if (busReq && !wb_we_i)
    begin
      case (wb_adr_i)
        `ADDR_STEER_CTRL:
          next_st.rdata = {24'h0, 3'h0, st.ctrl.steerUpdateSync, st.ctrl.steerEnable};
        `ADDR_CAPCOMP_CTRL:
          next_st.rdata = {26'h0, st.capcomp};
        `ADDR_STEER_STATUS:
          next_st.rdata = {27'h0, st.upd == pwm_steer_pkg::UPD_WAIT_PERIOD, st.activeEnable};
        default:
          next_st.rdata = 32'h0;
      endcase
    end
    // Applying the new selection: at once, or held until the period starts.
    case (st.upd)
      pwm_steer_pkg::UPD_IDLE:
      begin
        if (next_st.ctrl.steerEnable != st.activeEnable)
        begin
          if (next_st.ctrl.steerUpdateSync)
            next_st.upd = pwm_steer_pkg::UPD_WAIT_PERIOD;
          else
            next_st.activeEnable = next_st.ctrl.steerEnable;
        end
      end
      pwm_steer_pkg::UPD_WAIT_PERIOD:
      begin
        if (periodStart || !next_st.ctrl.steerUpdateSync)
        begin
          next_st.activeEnable = next_st.ctrl.steerEnable;
          next_st.upd = pwm_steer_pkg::UPD_IDLE;
        end
      end
      default:
        next_st.upd = pwm_steer_pkg::UPD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st.ctrl <= `STEER_CTRL_RESET;
      st.capcomp <= `CAPCOMP_CTRL_RESET;
      st.activeEnable <= 4'h1;
      st.upd <= pwm_steer_pkg::UPD_IDLE;
      st.rdata <= 32'h0;
      st.ack <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;

  genvar gi;
  generate
    for (gi = 0; gi < NumOut; gi++)
    begin : g_pin
      assign steerOn[gi] = steerMode && st.activeEnable[gi];
      pwm_pin_mux u_mux (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .steerOn(steerOn[gi]),
        .pwmLevel(pwmPolar),
        .portLevel(portData[gi]),
        .pinOut(pwmPin[gi])
      );
    end
  endgenerate

  property p_pin_a;
    @(posedge clk_sys) disable iff (!nrst)
      steerOn[0] |=> (pwmPin[0] == $past(pwmPolar));
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin A not PWM");

  property p_pin_b;
    @(posedge clk_sys) disable iff (!nrst)
      !steerOn[1] |=> (pwmPin[1] == $past(portData[1]));
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin B not port");

  property p_mode;
    @(posedge clk_sys) disable iff (!nrst)
      !steerMode |=> (pwmPin == $past(portData));
  endproperty
  a_mode: assert property (p_mode) else $error("steering outside mode");

  property p_polar;
    @(posedge clk_sys) disable iff (!nrst)
      (steerOn[1] && st.capcomp.capcompModeLow[0]) |=> (pwmPin[1] == !$past(pwmRaw));
  endproperty
  a_polar: assert property (p_polar) else $error("polarity wrong");

  sequence s_sync_wait;
    st.upd == pwm_steer_pkg::UPD_WAIT_PERIOD && !periodStart && st.ctrl.steerUpdateSync &&
      !(ctrlWrite && !wb_dat_i[`BIT_STEER_SYNC]);
  endsequence
  property p_sync_hold;
    @(posedge clk_sys) disable iff (!nrst)
      s_sync_wait |=> $stable(st.activeEnable);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("early steer update");

  property p_async;
    @(posedge clk_sys) disable iff (!nrst)
      (st.upd == pwm_steer_pkg::UPD_IDLE && !st.ctrl.steerUpdateSync)
        |-> (st.activeEnable == st.ctrl.steerEnable);
  endproperty
  a_async: assert property (p_async) else $error("late steer update");

  property p_ack;
    @(posedge clk_sys) disable iff (!nrst)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");

  property p_ack_drop;
    @(posedge clk_sys) disable iff (!nrst)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");

  sequence s_single_pwm;
    st.capcomp.capcompModeHigh == `CAPCOMP_PWM_MODE &&
      st.capcomp.pwmOutputConfig == `CAPCOMP_SINGLE_OUT;
  endsequence

  property p_steer_a;
    @(posedge clk_sys) disable iff (!nrst)
      (s_single_pwm ##0 st.activeEnable[0])
        |=> (pwmPin[0] == ($past(pwmRaw) ^ $past(st.capcomp.capcompModeLow[0])));
  endproperty
  a_steer_a: assert property (p_steer_a) else $error("pin A waveform wrong");

  property p_steer_b;
    @(posedge clk_sys) disable iff (!nrst)
      (s_single_pwm ##0 st.activeEnable[1])
        |=> (pwmPin[1] == ($past(pwmRaw) ^ $past(st.capcomp.capcompModeLow[0])));
  endproperty
  a_steer_b: assert property (p_steer_b) else $error("pin B waveform wrong");

  property p_steer_c;
    @(posedge clk_sys) disable iff (!nrst)
      (s_single_pwm ##0 st.activeEnable[2])
        |=> (pwmPin[2] == ($past(pwmRaw) ^ $past(st.capcomp.capcompModeLow[0])));
  endproperty
  a_steer_c: assert property (p_steer_c) else $error("pin C waveform wrong");

  property p_steer_d;
    @(posedge clk_sys) disable iff (!nrst)
      (s_single_pwm ##0 st.activeEnable[3])
        |=> (pwmPin[3] == ($past(pwmRaw) ^ $past(st.capcomp.capcompModeLow[0])));
  endproperty
  a_steer_d: assert property (p_steer_d) else $error("pin D waveform wrong");

  property p_pin_a_port;
    @(posedge clk_sys) disable iff (!nrst)
      !st.activeEnable[0] |=> (pwmPin[0] == $past(portData[0]));
  endproperty
  a_pin_a_port: assert property (p_pin_a_port) else $error("pin A not port");

  property p_pin_c_port;
    @(posedge clk_sys) disable iff (!nrst)
      !st.activeEnable[2] |=> (pwmPin[2] == $past(portData[2]));
  endproperty
  a_pin_c_port: assert property (p_pin_c_port) else $error("pin C not port");

  property p_pin_d_port;
    @(posedge clk_sys) disable iff (!nrst)
      !st.activeEnable[3] |=> (pwmPin[3] == $past(portData[3]));
  endproperty
  a_pin_d_port: assert property (p_pin_d_port) else $error("pin D not port");

  sequence s_direct_write;
    ctrlWrite ##0 !wb_dat_i[`BIT_STEER_SYNC];
  endsequence
  property p_direct_apply;
    @(posedge clk_sys) disable iff (!nrst)
      s_direct_write
        |=> (st.activeEnable == $past(wb_dat_i[3:0])) && (st.upd == pwm_steer_pkg::UPD_IDLE);
  endproperty
  a_direct_apply: assert property (p_direct_apply) else $error("direct update late");

  sequence s_sync_write;
    ctrlWrite ##0 wb_dat_i[`BIT_STEER_SYNC] ##0 (st.upd == pwm_steer_pkg::UPD_IDLE) ##0
      (wb_dat_i[3:0] != st.activeEnable);
  endsequence
  property p_sync_defer;
    @(posedge clk_sys) disable iff (!nrst)
      s_sync_write
        |=> $stable(st.activeEnable) && (st.upd == pwm_steer_pkg::UPD_WAIT_PERIOD);
  endproperty
  a_sync_defer: assert property (p_sync_defer) else $error("sync update not deferred");

  sequence s_period_hit;
    st.upd == pwm_steer_pkg::UPD_WAIT_PERIOD ##0 periodStart ##0 !ctrlWrite;
  endsequence
  property p_period_apply;
    @(posedge clk_sys) disable iff (!nrst)
      s_period_hit |=> (st.activeEnable == $past(st.ctrl.steerEnable)) &&
        (st.upd == pwm_steer_pkg::UPD_IDLE);
  endproperty
  a_period_apply: assert property (p_period_apply) else $error("period update lost");

  property p_ctrl_store;
    @(posedge clk_sys) disable iff (!nrst)
      ctrlWrite |=> (st.ctrl.steerEnable == $past(wb_dat_i[3:0])) &&
        (st.ctrl.steerUpdateSync == $past(wb_dat_i[`BIT_STEER_SYNC]));
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("steering register not written");

  property p_lane_ignore;
    @(posedge clk_sys) disable iff (!nrst)
      (busReq && wb_we_i && !wb_sel_i[0])
        |=> $stable(st.ctrl) && $stable(st.capcomp);
  endproperty
  a_lane_ignore: assert property (p_lane_ignore) else $error("write without lane 0 taken");

  property p_unmapped_read;
    @(posedge clk_sys) disable iff (!nrst)
      (busReq && !wb_we_i && !(wb_adr_i inside {`ADDR_STEER_CTRL, `ADDR_CAPCOMP_CTRL,
        `ADDR_STEER_STATUS})) |=> (wb_dat_o == 32'h0);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!nrst)
      !wb_ack_o |-> (wb_dat_o == 32'h0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack");

  property p_ack_needs_req;
    @(posedge clk_sys) disable iff (!nrst)
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");
endmodule : pwm_output_steering

// ==== rtl/pwm_pin_mux.sv ====
// One output pin of the steering logic: PWM or ordinary port function.
module pwm_pin_mux (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic steerOn,
  input wire logic pwmLevel,
  input wire logic portLevel,
  output logic pinOut
);
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pinOut <= 1'b0;
    else
      pinOut <= steerOn ? pwmLevel : portLevel;
  end
endmodule : pwm_pin_mux

// ==== rtl/pwm_steer_defs.svh ====
// Register offsets, field positions, reset values, mode codes and output count of the PWM steering block.
`ifndef PWM_STEER_DEFS_SVH
`define PWM_STEER_DEFS_SVH
`define ADDR_STEER_CTRL 4'h0
`define ADDR_CAPCOMP_CTRL 4'h4
`define ADDR_STEER_STATUS 4'h8
`define STEER_CTRL_RESET 8'h01
`define CAPCOMP_CTRL_RESET 6'h00
`define BIT_STEER_SYNC 4
`define CAPCOMP_PWM_MODE 2'h3
`define CAPCOMP_SINGLE_OUT 2'h0
`define NUM_OUTPUTS 4
`endif

// ==== rtl/pwm_steer_pkg.sv ====
// Types shared by the PWM steering block.
package pwm_steer_pkg;
  typedef struct packed {
    logic [2:0] unused;
    logic steerUpdateSync;
    logic [3:0] steerEnable;
  } steer_ctrl_s;
  typedef struct packed {
    logic [1:0] pwmOutputConfig;
    logic [1:0] capcompModeHigh;
    logic [1:0] capcompModeLow;
  } capcomp_s;
  typedef enum logic [1:0] {
    UPD_IDLE = 2'b00,
    UPD_WAIT_PERIOD = 2'b01
  } update_e;
endpackage : pwm_steer_pkg

// ==== tb/pwm_load_model.sv ====
// External load that samples the steered pins.
module pwm_load_model (
  input wire logic clk_sys,
  input wire logic [3:0] pinLevel,
  output logic [3:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_sys)
  begin
    seen <= pinLevel;
  end
endmodule : pwm_load_model

// ==== tb/pwm_output_steering_tb.sv ====
// Register and pin tests of the steering block.
`include "pwm_steer_defs.svh"
module pwm_output_steering_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, wbWe = 1'b0, ack;
  logic pwmRaw = 1'b0, periodStart = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0, laneSel = 4'h1, portData = 4'h0, pwmPin, seen;
  logic [31:0] dat = 32'h0, rdat, q;
  int badCount = 0, cmpCount = 0, tick = 0;
  always #12.5 clk_sys = ~clk_sys;
  pwm_output_steering i_pwm_output_steering (.clk_sys(clk_sys), .nrst(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wbWe), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .pwmRaw(pwmRaw),
    .periodStart(periodStart), .portData(portData), .pwmPin(pwmPin));
  pwm_load_model i_pwm_load_model (.clk_sys(clk_sys), .pinLevel(pwmPin), .seen(seen));
  task automatic wrap_up();
    $display("compares %0d errors %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmpCount++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      badCount++;
    end
  endtask : chk
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbWe <= we;
    adr <= a;
    dat <= {24'h0, d};
    sel <= laneSel;
    @(posedge clk_sys);
    while (ack !== 1'b1)
      @(posedge clk_sys);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task automatic pins(input logic [3:0] e);
    repeat (3) @(posedge clk_sys);
    chk("pins", {28'h0, e}, {28'h0, seen});
  endtask : pins
  always @(posedge clk_sys)
  begin
    tick++;
    if (tick == 3000)
    begin
      badCount++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    wb(1'b0, `ADDR_STEER_CTRL, 8'h00);
    chk("ctrl", 32'h01, q);
    wb(1'b0, `ADDR_CAPCOMP_CTRL, 8'h00);
    chk("capcomp", 32'h00, q);
    wb(1'b0, `ADDR_STEER_STATUS, 8'h00);
    chk("status", 32'h01, q);
    wb(1'b1, 4'hc, 8'hff);
    wb(1'b0, 4'hc, 8'h00);
    chk("unmapped", 32'h0, q);
    laneSel = 4'h2;
    wb(1'b1, `ADDR_STEER_CTRL, 8'h0e);
    laneSel = 4'h1;
    wb(1'b0, `ADDR_STEER_CTRL, 8'h00);
    chk("ctrl", 32'h01, q);
    portData <= 4'ha;
    pwmRaw <= 1'b1;
    pins(4'ha);
    wb(1'b1, `ADDR_CAPCOMP_CTRL, 8'h0c);
    wb(1'b0, `ADDR_CAPCOMP_CTRL, 8'h00);
    chk("capcomp", 32'h0c, q);
    pins(4'hb);
    wb(1'b1, `ADDR_STEER_CTRL, 8'h03);
    portData <= 4'h0;
    pins(4'h3);
    pwmRaw <= 1'b0;
    portData <= 4'hc;
    pins(4'hc);
    wb(1'b1, `ADDR_CAPCOMP_CTRL, 8'h0d);
    pins(4'hf);
    wb(1'b1, `ADDR_CAPCOMP_CTRL, 8'h1d);
    pins(4'hc);
    wb(1'b1, `ADDR_CAPCOMP_CTRL, 8'h09);
    pins(4'hc);
    wb(1'b1, `ADDR_CAPCOMP_CTRL, 8'h0c);
    pwmRaw <= 1'b1;
    portData <= 4'h0;
    wb(1'b1, `ADDR_STEER_CTRL, 8'h14);
    wb(1'b0, `ADDR_STEER_STATUS, 8'h00);
    chk("status", 32'h13, q);
    wb(1'b0, `ADDR_STEER_CTRL, 8'h00);
    chk("ctrl", 32'h14, q);
    pins(4'h3);
    periodStart <= 1'b1;
    @(posedge clk_sys);
    periodStart <= 1'b0;
    pins(4'h4);
    wb(1'b1, `ADDR_STEER_CTRL, 8'h18);
    pins(4'h4);
    wb(1'b1, `ADDR_STEER_CTRL, 8'h09);
    wb(1'b0, `ADDR_STEER_STATUS, 8'h00);
    chk("status", 32'h09, q);
    pins(4'h9);
    wrap_up();
  end
endmodule : pwm_output_steering_tb
